/* include/cis_pkg.sv */
// Purpose: Shared constants and types for the instruction subset executor
// Assumes: One 25 MHz core clock, 16-bit data path, 23-bit code addresses
// Notes:   Contract list below is tagged in the logic
//
// Contract
// RULE_01 - Decimal adjust in place, one cycle, carry only
// RULE_02 - Block interrupts for literal cycles, flags untouched
// RULE_03 - Literal loop runs body literal plus one
// RULE_04 - Register loop runs body register plus one
// RULE_05 - Sign change scan from top, carry only
// RULE_06 - First one from top, carry only
// RULE_07 - First one from bottom, carry only
// RULE_08 - Shift right by register, zero fill, N Z
// RULE_09 - Single shift to work register, four flags
// RULE_10 - Jumps take four cycles, no flags
// RULE_11 - Non-core special register read adds a cycle
// RULE_12 - Increment decrement one cycle, all five flags
package cis_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 23;

    // Execution cycle counts
    localparam logic [2:0] CYC_SINGLE    = 3'h1;
    localparam logic [2:0] CYC_LOOP      = 3'h2;
    localparam logic [2:0] CYC_JUMP      = 3'h4;
    localparam logic [2:0] CYC_REG_EXTRA = 3'h1;

    // Reset values
    localparam logic [13:0] IRQ_CNT_RST  = 14'h0000;
    localparam logic [15:0] WORD_RST     = 16'h0000;
    localparam logic [22:0] ADDR_RST     = 23'h000000;

    // Code address step of a two-word instruction
    localparam logic [22:0] TWO_WORD_STEP = 23'h000004;

    // Flag write masks, order C DC N OV Z
    localparam logic [4:0] MASK_NONE  = 5'h00;
    localparam logic [4:0] MASK_C     = 5'h10;
    localparam logic [4:0] MASK_NZ    = 5'h05;
    localparam logic [4:0] MASK_CNOVZ = 5'h17;
    localparam logic [4:0] MASK_ALL   = 5'h1F;

    typedef enum logic [3:0] {
        OP_DECIMAL_ADJUST = 4'h0,
        OP_IRQ_BLOCK      = 4'h1,
        OP_LOOP_LIT       = 4'h2,
        OP_LOOP_REG       = 4'h3,
        OP_SIGN_SCAN      = 4'h4,
        OP_MSB_SCAN       = 4'h5,
        OP_LSB_SCAN       = 4'h6,
        OP_SHIFT_BY_REG   = 4'h7,
        OP_SHIFT_ONE      = 4'h8,
        OP_JUMP_DIRECT    = 4'h9,
        OP_JUMP_INDIRECT  = 4'hA,
        OP_JUMP_LONG      = 4'hB,
        OP_INC_ONE        = 4'hC,
        OP_INC_TWO        = 4'hD,
        OP_DEC_ONE        = 4'hE,
        OP_DEC_TWO        = 4'hF
    } cis_op_type;

    typedef enum logic [1:0] {
        SCAN_SIGN = 2'h0,
        SCAN_MSB  = 2'h1,
        SCAN_LSB  = 2'h2
    } cis_scan_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } cis_state_type;

    typedef struct packed {
        logic c;
        logic dc;
        logic n;
        logic ov;
        logic z;
    } cis_flags_type;

    typedef struct packed {
        cis_state_type  st;
        logic [2:0]     cnt;
        logic [15:0]    result;
        logic           resultWe;
        logic           destWork;
        cis_flags_type  flags;
        logic [4:0]     flagMask;
        logic           jumpTake;
        logic [22:0]    jumpTarget;
        logic [13:0]    irqCnt;
        logic           loopActive;
        logic [15:0]    loopRemain;
        logic [22:0]    loopStart;
        logic [22:0]    loopEnd;
    } cis_core_type;

endpackage : cis_pkg

/* include/cis_scan_if.sv */
// Purpose: Carries a bit scan request and its answer
// Assumes: Purely combinational answer in the same cycle
// Notes:   Position zero means no bit found
`timescale 1ns/100ps
interface cis_scan_if;
    import cis_pkg::*;
    cis_scan_type mode;
    logic [15:0]  data;
    logic [4:0]   pos;
    logic         none;

    modport req (output mode, output data, input pos, input none);
    modport res (input mode, input data, output pos, output none);
endinterface : cis_scan_if

/* logic/cis_bit_scan.sv */
// Purpose: Bit position finder for the three scan instructions
// Assumes: Operand stable for the cycle it is sampled
// Notes:   Positions are 1-based, counted from the scan start; the sign scan counts from the bit below the sign bit
`timescale 1ns/100ps
module cis_bit_scan
    import cis_pkg::*;
(
    cis_scan_if.res scan
);

    // Priority search; first hit from the scan start wins
    always_comb begin
        logic found;
        found     = 1'b0;
        scan.pos  = 5'h00;
        for (int i = 0; i < DATA_W; i++) begin
            case (scan.mode)
                SCAN_SIGN: begin
                    // Sign bit never differs from itself; hits start at 1
                    if (!found && scan.data[DATA_W - 1 - i] !=
                        scan.data[DATA_W - 1]) begin // [RULE_05]
                        found    = 1'b1;
                        scan.pos = 5'(i);
                    end
                end
                SCAN_MSB: begin
                    if (!found && scan.data[DATA_W - 1 - i]) begin // [RULE_06]
                        found    = 1'b1;
                        scan.pos = 5'(i + 1);
                    end
                end
                default: begin
                    if (!found && scan.data[i]) begin // [RULE_07]
                        found    = 1'b1;
                        scan.pos = 5'(i + 1);
                    end
                end
            endcase
        end
        scan.none = !found;
    end

endmodule : cis_bit_scan

/* logic/cis_exec.sv */
// Purpose: Executes a subset of the core instructions on decoded operands
// Assumes: Front end holds the request stable while opValid is high
// Notes:   One instruction in flight; done marks the final cycle
`timescale 1ns/100ps
module cis_exec
    import cis_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    input  wire logic          opValid,
    output      logic          opReady,
    input  wire cis_op_type    opCode,
    input  wire logic [15:0]   srcA,
    input  wire logic [15:0]   srcB,
    input  wire logic [22:0]   literal,
    input  wire logic [22:0]   pcIn,
    input  wire logic          toWorkReg,
    input  wire logic          offCoreReg,
    input  wire cis_flags_type flagsIn,
    input  wire logic          loopEndHit,
    output      logic          done,
    output      logic [15:0]   result,
    output      logic          resultWe,
    output      logic          destWork,
    output      cis_flags_type flagsOut,
    output      logic [4:0]    flagMask,
    output      logic          jumpTake,
    output      logic [22:0]   jumpTarget,
    output      logic          irqBlock,
    output      logic          loopActive,
    output      logic [15:0]   loopRemain,
    output      logic [22:0]   loopStart,
    output      logic [22:0]   loopEnd
);

    cis_core_type core_reg;
    cis_core_type core_next;
    logic         rstMeta_reg;
    logic         rstSyncB_reg;
    logic         opTake;
    logic [16:0]  sum;
    logic [4:0]   lowSum;
    logic [15:0]  addend;
    logic [2:0]   cycles;
    logic [15:0]  bcdVal;
    logic         bcdHigh;

    cis_scan_if scanBus ();

    cis_bit_scan u_scan (
        .scan (scanBus)
    );

    // Reset release through two stages; assert stays asynchronous
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_reg  <= 1'b0;
            rstSyncB_reg <= 1'b0;
        end else begin
            rstMeta_reg  <= 1'b1;
            rstSyncB_reg <= rstMeta_reg;
        end
    end

    assign opReady = (core_reg.st == ST_IDLE);
    assign opTake  = opValid && opReady;
    assign done    = (core_reg.st == ST_EXEC) && (core_reg.cnt == 3'h0);

    // Scan unit sees the source operand directly
    always_comb begin
        case (opCode)
            OP_SIGN_SCAN: scanBus.mode = SCAN_SIGN;
            OP_MSB_SCAN:  scanBus.mode = SCAN_MSB;
            default:      scanBus.mode = SCAN_LSB;
        endcase
        scanBus.data = srcA;
    end

    // Shared adder for the four step forms
    always_comb begin
        if (opCode == OP_INC_TWO || opCode == OP_DEC_TWO) begin
            addend = 16'h0002;
        end else begin
            addend = 16'h0001;
        end
        if (opCode == OP_DEC_ONE || opCode == OP_DEC_TWO) begin
            // Subtract as add of complement so carry means no borrow
            sum    = {1'b0, srcA} + {1'b0, ~addend} + 17'h00001;
            lowSum = {1'b0, srcA[3:0]} + {1'b0, ~addend[3:0]} + 5'h01;
        end else begin
            sum    = {1'b0, srcA} + {1'b0, addend};
            lowSum = {1'b0, srcA[3:0]} + {1'b0, addend[3:0]};
        end
    end

    // Decimal correction of the low byte, upper byte passes through
    always_comb begin
        logic [8:0] tmp;
        tmp = {1'b0, srcA[7:0]};
        if (srcA[3:0] > 4'h9 || flagsIn.dc) begin
            tmp = tmp + 9'h006;
        end
        bcdHigh = (tmp[8:4] > 5'h09) || flagsIn.c;
        if (bcdHigh) begin
            tmp = tmp + 9'h060;
        end
        bcdVal = {srcA[15:8], tmp[7:0]};
    end

    // Listed cycle count plus the bus penalty for non-core registers
    always_comb begin
        case (opCode)
            OP_LOOP_LIT, OP_LOOP_REG: cycles = CYC_LOOP;
            OP_JUMP_DIRECT, OP_JUMP_INDIRECT, OP_JUMP_LONG:
                cycles = CYC_JUMP;
            default: cycles = CYC_SINGLE;
        endcase
        if (offCoreReg) begin
            cycles = cycles + CYC_REG_EXTRA; // [RULE_11]
        end
    end

    // Next state of the whole core
    always_comb begin
        core_next = core_reg;
        // Interrupt hold-off counts down once per instruction cycle
        if (core_reg.irqCnt != IRQ_CNT_RST) begin
            core_next.irqCnt = core_reg.irqCnt - 14'h0001;
        end
        // Loop end seen by fetch: another pass or leave the loop
        if (core_reg.loopActive && loopEndHit) begin
            if (core_reg.loopRemain == WORD_RST) begin
                core_next.loopActive = 1'b0;
            end else begin
                core_next.loopRemain = core_reg.loopRemain - 16'h0001;
            end
        end
        case (core_reg.st)
            ST_IDLE: begin
                if (opTake) begin
                    core_next.st         = ST_EXEC;
                    core_next.cnt        = cycles - 3'h1;
                    core_next.resultWe   = 1'b0;
                    core_next.destWork   = 1'b0;
                    core_next.flags      = flagsIn;
                    core_next.flagMask   = MASK_NONE;
                    core_next.jumpTake   = 1'b0;
                    case (opCode)
                        OP_DECIMAL_ADJUST: begin
                            core_next.result   = bcdVal; // [RULE_01]
                            core_next.resultWe = 1'b1;
                            core_next.flags.c  = bcdHigh;
                            core_next.flagMask = MASK_C;
                        end
                        OP_IRQ_BLOCK: begin
                            core_next.irqCnt = literal[13:0]; // [RULE_02]
                        end
                        OP_LOOP_LIT, OP_LOOP_REG: begin
                            core_next.loopActive = 1'b1;
                            if (opCode == OP_LOOP_LIT) begin
                                // Body passes = count + 1
                                core_next.loopRemain =
                                    {1'b0, literal[14:0]}; // [RULE_03]
                            end else begin
                                core_next.loopRemain = srcA; // [RULE_04]
                            end
                            core_next.loopStart = pcIn + TWO_WORD_STEP;
                            core_next.loopEnd   = pcIn + {7'h00, srcB};
                        end
                        OP_SIGN_SCAN, OP_MSB_SCAN, OP_LSB_SCAN: begin
                            core_next.result   = {11'h000, scanBus.pos};
                            core_next.resultWe = 1'b1;
                            core_next.flags.c  = scanBus.none; // [RULE_06]
                            core_next.flagMask = MASK_C; // [RULE_05] [RULE_07]
                        end
                        OP_SHIFT_BY_REG: begin
                            // Amounts of sixteen to 31 clear the word; only srcB[4:0] is used
                            core_next.result   = srcA >> srcB[4:0]; // [RULE_08]
                            core_next.resultWe = 1'b1;
                            core_next.flags.n  = 1'b0;
                            core_next.flags.z  = (srcB[4] || srcA == WORD_RST) ?
                                                 1'b1 :
                                                 ((srcA >> srcB[3:0]) ==
                                                  WORD_RST);
                            core_next.flagMask = MASK_NZ;
                        end
                        OP_SHIFT_ONE: begin
                            core_next.result   = {1'b0, srcA[15:1]};
                            core_next.resultWe = 1'b1;
                            core_next.destWork = toWorkReg; // [RULE_09]
                            core_next.flags.c  = srcA[0];
                            core_next.flags.n  = 1'b0;
                            core_next.flags.ov = 1'b0;
                            core_next.flags.z  = (srcA[15:1] == 15'h0000);
                            core_next.flagMask = MASK_CNOVZ;
                        end
                        OP_JUMP_DIRECT: begin
                            core_next.jumpTake   = 1'b1; // [RULE_10]
                            core_next.jumpTarget = literal;
                        end
                        OP_JUMP_INDIRECT: begin
                            core_next.jumpTake   = 1'b1;
                            core_next.jumpTarget =
                                {7'h00, srcA[15:1], 1'b0};
                        end
                        OP_JUMP_LONG: begin
                            core_next.jumpTake   = 1'b1;
                            core_next.jumpTarget =
                                {srcB[6:0], srcA[15:1], 1'b0};
                        end
                        default: begin
                            core_next.result   = sum[15:0]; // [RULE_12]
                            core_next.resultWe = 1'b1;
                            core_next.destWork = toWorkReg;
                            core_next.flags.c  = sum[16];
                            core_next.flags.dc = lowSum[4];
                            core_next.flags.n  = sum[15];
                            core_next.flags.ov = (srcA[15] == addend[15] ^
                                (opCode == OP_DEC_ONE ||
                                 opCode == OP_DEC_TWO)) &&
                                (sum[15] != srcA[15]);
                            core_next.flags.z  = (sum[15:0] == WORD_RST);
                            core_next.flagMask = MASK_ALL;
                        end
                    endcase
                end
            end
            ST_EXEC: begin
                if (core_reg.cnt == 3'h0) begin
                    core_next.st = ST_IDLE;
                end else begin
                    core_next.cnt = core_reg.cnt - 3'h1;
                end
            end
            default: begin
                core_next.st = ST_IDLE;
            end
        endcase
    end

    // Single state register
    always_ff @(posedge core_clk or negedge rstSyncB_reg) begin
        if (!rstSyncB_reg) begin
            core_reg <= '{st: ST_IDLE, cnt: 3'h0, result: WORD_RST,
                          resultWe: 1'b0, destWork: 1'b0,
                          flags: 5'h00, flagMask: MASK_NONE,
                          jumpTake: 1'b0, jumpTarget: ADDR_RST,
                          irqCnt: IRQ_CNT_RST, loopActive: 1'b0,
                          loopRemain: WORD_RST, loopStart: ADDR_RST,
                          loopEnd: ADDR_RST};
        end else begin
            core_reg <= core_next;
        end
    end

    assign result     = core_reg.result;
    assign resultWe   = core_reg.resultWe;
    assign destWork   = core_reg.destWork;
    assign flagsOut   = core_reg.flags;
    assign flagMask   = core_reg.flagMask;
    assign jumpTake   = core_reg.jumpTake;
    assign jumpTarget = core_reg.jumpTarget;
    assign irqBlock   = (core_reg.irqCnt != IRQ_CNT_RST);
    assign loopActive = core_reg.loopActive;
    assign loopRemain = core_reg.loopRemain;
    assign loopStart  = core_reg.loopStart;
    assign loopEnd    = core_reg.loopEnd;

    // Checks on timing and effects
    chk_bcd_carry_only: assert property (@(posedge core_clk) // [RULE_01]
        disable iff (!rstSyncB_reg)
        opTake && opCode == OP_DECIMAL_ADJUST && !offCoreReg
        |=> flagMask == MASK_C && done)
        else $error("decimal adjust flags or timing wrong");

    chk_irq_hold_load: assert property (@(posedge core_clk) // [RULE_02]
        disable iff (!rstSyncB_reg)
        opTake && opCode == OP_IRQ_BLOCK && literal[13:0] > 14'h0001
        |=> irqBlock && flagMask == MASK_NONE ##1 irqBlock)
        else $error("interrupt hold-off not started");

    chk_loop_two_cycles: assert property (@(posedge core_clk) // [RULE_03]
        disable iff (!rstSyncB_reg)
        opTake && opCode == OP_LOOP_LIT && !offCoreReg
        |=> !done ##1 done && loopActive
            && loopRemain == {1'b0, $past(literal[14:0], 2)})
        else $error("literal loop setup wrong");

    chk_loop_reg_count: assert property (@(posedge core_clk) // [RULE_04]
        disable iff (!rstSyncB_reg)
        opTake && opCode == OP_LOOP_REG
        |=> loopActive && loopRemain == $past(srcA)
            && flagMask == MASK_NONE)
        else $error("register loop count wrong");

    chk_msb_scan_one: assert property (@(posedge core_clk) // [RULE_06]
        disable iff (!rstSyncB_reg)
        opTake && opCode == OP_MSB_SCAN && !offCoreReg
        |=> done && flagMask == MASK_C
            && flagsOut.c == ($past(srcA) == WORD_RST)
            && (!$past(srcA[15]) || result == 16'h0001))
        else $error("top scan position wrong");

    chk_shift_reg_amt: assert property (@(posedge core_clk) // [RULE_08]
        disable iff (!rstSyncB_reg)
        opTake && opCode == OP_SHIFT_BY_REG
        |=> result == ($past(srcA) >> $past(srcB[4:0]))
            && flagMask == MASK_NZ)
        else $error("register shift result wrong");

    chk_shift_work_dest: assert property (@(posedge core_clk) // [RULE_09]
        disable iff (!rstSyncB_reg)
        opTake && opCode == OP_SHIFT_ONE
        |=> destWork == $past(toWorkReg) && flagsOut.c == $past(srcA[0])
            && flagMask == MASK_CNOVZ)
        else $error("single shift destination wrong");

    chk_jump_four_cyc: assert property (@(posedge core_clk) // [RULE_10]
        disable iff (!rstSyncB_reg)
        opTake && opCode inside {OP_JUMP_DIRECT, OP_JUMP_INDIRECT,
                                 OP_JUMP_LONG} && !offCoreReg
        |=> !done [*3] ##1 done && jumpTake && flagMask == MASK_NONE)
        else $error("jump timing wrong");

    chk_reg_extra_cyc: assert property (@(posedge core_clk) // [RULE_11]
        disable iff (!rstSyncB_reg)
        opTake && opCode == OP_INC_ONE && offCoreReg
        |=> !done ##1 done)
        else $error("extra bus cycle missing");

    chk_inc_result: assert property (@(posedge core_clk) // [RULE_12]
        disable iff (!rstSyncB_reg)
        opTake && opCode == OP_INC_ONE && !offCoreReg
        |=> done && result == $past(srcA) + 16'h0001
            && flagMask == MASK_ALL)
        else $error("increment wrong");

endmodule : cis_exec

/* testbench/cis_fetch_model.sv */
// Purpose: Fetch side stand-in that reports loop end hits
// Assumes: Body length fixed at GAP plus one cycles per pass
// Notes:   Hit is a one-cycle pulse, low outside active loops
`timescale 1ns/100ps
module cis_fetch_model #(
    parameter int GAP = 4
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic loopActive,
    output      logic loopEndHit
);
    int phase_reg;

    // Pulse once per pass; a long GAP models a slow loop body
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg  <= 0;
            loopEndHit <= 1'b0;
        end else if (loopActive && !loopEndHit) begin
            phase_reg  <= (phase_reg == GAP - 1) ? 0 : phase_reg + 1;
            loopEndHit <= (phase_reg == GAP - 1);
        end else begin
            phase_reg  <= 0;
            loopEndHit <= 1'b0;
        end
    end
endmodule : cis_fetch_model

/* testbench/cpu_instruction_subset_exec_bench.sv */
// Purpose: Self-checking bench for the instruction subset executor
// Assumes: Executor idle between requests, one request in flight
// Notes:   Cycle count is the number of cycles from take to done
`timescale 1ns/100ps
module cpu_instruction_subset_exec_bench;
    import cis_pkg::*;
    logic          core_clk, rst_b, opValid, opReady, toWorkReg;
    logic          offCoreReg, loopEndHit, done, resultWe, destWork;
    logic          jumpTake, irqBlock, loopActive;
    cis_op_type    opCode;
    logic [15:0]   srcA, srcB, result, loopRemain;
    logic [22:0]   literal, pcIn, jumpTarget, loopStart, loopEnd;
    cis_flags_type flagsIn, flagsOut;
    logic [4:0]    flagMask;
    int            nErrors, testsRun, cyc, k;

    cis_exec u_cis_exec (.core_clk(core_clk), .rst_b(rst_b),
        .opValid(opValid), .opReady(opReady), .opCode(opCode),
        .srcA(srcA), .srcB(srcB), .literal(literal), .pcIn(pcIn),
        .toWorkReg(toWorkReg), .offCoreReg(offCoreReg),
        .flagsIn(flagsIn), .loopEndHit(loopEndHit), .done(done),
        .result(result), .resultWe(resultWe), .destWork(destWork),
        .flagsOut(flagsOut), .flagMask(flagMask),
        .jumpTake(jumpTake), .jumpTarget(jumpTarget),
        .irqBlock(irqBlock), .loopActive(loopActive),
        .loopRemain(loopRemain), .loopStart(loopStart),
        .loopEnd(loopEnd));
    cis_fetch_model u_cis_fetch_model (.core_clk(core_clk),
        .rst_b(rst_b), .loopActive(loopActive),
        .loopEndHit(loopEndHit));

    // Free running 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic finishTest;
        if (nErrors == 0 && testsRun > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finishTest

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One request; returns with cyc cycles counted up to done
    task automatic run(input cis_op_type op, input logic [15:0] a, b,
                       input logic [22:0] lit, input logic s, w);
        @(posedge core_clk);
        opValid <= 1'b1;
        opCode <= op;
        srcA <= a;
        srcB <= b;
        literal <= lit;
        offCoreReg <= s;
        toWorkReg <= w;
        @(posedge core_clk);
        opValid <= 1'b0;
        cyc = 0;
        do begin
            @(negedge core_clk);
            cyc++;
        end while (done !== 1'b1 && cyc < 20);
    endtask : run

    // Reference sum with C DC N OV Z above the 16-bit value
    function automatic logic [20:0] arith(logic [15:0] a, kk, logic sub);
        logic [15:0] bb;
        logic [16:0] s;
        logic [4:0]  h;
        bb = sub ? ~kk : kk;
        s  = a + bb + sub;
        h  = a[3:0] + bb[3:0] + sub;
        return {s[16], h[4], s[15], (a[15] == bb[15]) && (s[15] != a[15]),
                s[15:0] == 16'h0000, s[15:0]};
    endfunction : arith

    // Carry, wrap and overflow edges of all four step ops
    task automatic testIncDec;
        logic [15:0] av [4] = '{16'hFFFF, 16'h7FFF, 16'h0000, 16'h0001};
        logic [20:0] e;
        for (int i = 0; i < 4; i++) begin
            e = arith(av[i], i[0] ? 16'h0002 : 16'h0001, i[1]);
            run(cis_op_type'(4'hC + i), av[i], 16'h0000, 23'h0, 1'b0, i[0]);
            chk(23'(cyc), 23'h1);
            chk(result, e[15:0]);
            chk(flagsOut, e[20:16]);
            chk({flagMask, resultWe, opReady}, {MASK_ALL, 2'h2});
            chk(destWork, i[0]);
        end
    endtask : testIncDec

    // Scans with a hit, plus the empty operand
    task automatic testScan;
        run(OP_MSB_SCAN, 16'h0100, 16'h0, 23'h0, 1'b0, 1'b0);
        chk({cyc[1:0], result}, {2'h1, 16'h0008});
        chk({flagMask, flagsOut.c}, {MASK_C, 1'b0});
        run(OP_LSB_SCAN, 16'h0100, 16'h0, 23'h0, 1'b0, 1'b0);
        chk({cyc[1:0], result}, {2'h1, 16'h0009});
        run(OP_LSB_SCAN, 16'h0000, 16'h0, 23'h0, 1'b0, 1'b0);
        chk({flagMask, flagsOut.c, result}, {MASK_C, 17'h10000});
        run(OP_SIGN_SCAN, 16'hF000, 16'h0, 23'h0, 1'b0, 1'b0);
        chk({cyc[1:0], result}, {2'h1, 16'h0004});
        chk(flagMask, MASK_C);
    endtask : testScan

    // Shifts, including an amount equal to the width and work register dest
    task automatic testShift;
        run(OP_SHIFT_BY_REG, 16'h8421, 16'h0004, 23'h0, 1'b0, 1'b0);
        chk({flagMask, flagsOut.n, flagsOut.z}, {MASK_NZ, 2'h0});
        chk(result, 16'h0842);
        run(OP_SHIFT_BY_REG, 16'hFFFF, 16'h0010, 23'h0, 1'b0, 1'b0);
        chk({result, flagsOut.z}, 17'h00001);
        run(OP_SHIFT_ONE, 16'h0003, 16'h0, 23'h0, 1'b0, 1'b1);
        chk({result, destWork, flagsOut.c}, {16'h0001, 2'h3});
        chk(flagMask, MASK_CNOVZ);
    endtask : testShift

    // Low nibble over nine, high nibble nine; upper byte must pass through
    task automatic testDecAdj;
        run(OP_DECIMAL_ADJUST, 16'h129A, 16'h0, 23'h0, 1'b0, 1'b0);
        chk({cyc[1:0], result}, {2'h1, 16'h1200});
        chk({flagMask, flagsOut.c}, {MASK_C, 1'b1});
    endtask : testDecAdj

    // Largest count; literal bits above 13 must be ignored
    task automatic testIrqBlock;
        run(OP_IRQ_BLOCK, 16'h0, 16'h0, 23'h7FFFFF, 1'b0, 1'b0);
        chk({23'(cyc), flagMask}, {23'h1, MASK_NONE});
        k = 1;
        while (k < 20000) begin
            @(negedge core_clk);
            if (irqBlock !== 1'b1) break;
            k++;
        end
        chk(23'(k), 23'h3FFF);
    endtask : testIrqBlock

    task automatic countHits;
        k = 0;
        for (int i = 0; i < 200 && loopActive === 1'b1; i++) begin
            @(negedge core_clk);
            if (loopEndHit === 1'b1) k++;
        end
    endtask : countHits

    // Literal loop with bit 15 set, register loop at zero
    task automatic testLoops;
        run(OP_LOOP_LIT, 16'h0, 16'h0010, 23'h008002, 1'b0, 1'b0);
        chk({23'(cyc), loopActive}, {23'h2, 1'b1});
        chk({loopActive, loopRemain}, {1'b1, 16'h0002});
        chk({loopStart, loopEnd}, {23'h104, 23'h110});
        countHits;
        chk(23'(k), 23'h3);
        run(OP_LOOP_REG, 16'h0000, 16'h0020, 23'h0, 1'b0, 1'b0);
        chk({23'(cyc), flagMask}, {23'h2, MASK_NONE});
        countHits;
        chk(23'(k), 23'h1);
    endtask : testLoops

    // All three jump forms, then the non-core register penalty
    task automatic testJumps;
        run(OP_JUMP_DIRECT, 16'h0, 16'h0, 23'h123456, 1'b0, 1'b0);
        chk({23'(cyc), flagMask}, {23'h4, MASK_NONE});
        chk({resultWe, opReady}, 2'h0);
        chk({jumpTake, jumpTarget}, {1'b1, 23'h123456});
        run(OP_JUMP_INDIRECT, 16'h2468, 16'h0, 23'h0, 1'b0, 1'b0);
        chk({23'(cyc), jumpTarget}, {23'h4, 23'h002468});
        run(OP_JUMP_LONG, 16'h2468, 16'h0055, 23'h0, 1'b0, 1'b0);
        chk({23'(cyc), jumpTarget}, {23'h4, 23'h552468});
        run(OP_INC_ONE, 16'h0001, 16'h0, 23'h0, 1'b1, 1'b0);
        chk({23'(cyc), result}, {23'h2, 16'h0002});
        run(OP_JUMP_DIRECT, 16'h0, 16'h0, 23'h000200, 1'b1, 1'b0);
        chk(23'(cyc), 23'h5);
    endtask : testJumps

    // Main sequence
    initial begin
        nErrors = 0;
        testsRun = 0;
        rst_b = 1'b0;
        opValid = 1'b0;
        opCode = OP_INC_ONE;
        srcA = 16'h0;
        srcB = 16'h0;
        literal = 23'h0;
        pcIn = 23'h000100;
        toWorkReg = 1'b0;
        offCoreReg = 1'b0;
        flagsIn = '0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        testIncDec;
        testScan;
        testShift;
        testDecAdj;
        testIrqBlock;
        testLoops;
        testJumps;
        finishTest;
    end

    // Watchdog well past the longest count
    initial begin
        repeat (40000) @(posedge core_clk);
        nErrors++;
        finishTest;
    end
endmodule : cpu_instruction_subset_exec_bench
